// *** hdl/halt_wakeup_and_ports.v ***
/*
  Halt control, wake-up logic, input ports and output port of a small
  4-bit controller, with an Avalon-MM register slave.
  Assumes the core pulses halt_instr at the start of the halt instruction,
  pulses port_write_instr with port_wdata, supplies next_pc, int_enable and
  in_subroutine, and honours pc_load, call_push and sys_clk_run.
*/
`timescale 1ns/10ps
`default_nettype none
`include "halt_wakeup_defines.vh"

module halt_wakeup_and_ports #(
  parameter [7:0] WAKE_MASK = 8'hFF,
  parameter [7:0] PULLUP_MASK = 8'hFF,
  parameter [2:0] OPEN_DRAIN_MASK = 3'h0,
  parameter integer LCD_TAP = 15,
  parameter integer SOUND_TAP = 3,
  parameter integer TIMER_TAP = 7
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire halt_instr,
  input wire port_write_instr,
  input wire [3:0] port_wdata,
  input wire int_enable,
  input wire in_subroutine,
  input wire [11:0] next_pc,
  output reg pc_load,
  output reg [11:0] pc_load_value,
  output reg call_push,
  output wire sys_clk_run,
  output wire osc_restart,
  output wire lcd_blank,
  output wire first_cycle_state,
  output wire last_cycle_state,
  output wire lcd_clk,
  output wire sound_clk,
  output wire timer_src,
  input wire [3:0] first_input_port,
  input wire [3:0] second_input_port,
  output wire [7:0] pullup_en,
  output reg [7:0] port_in,
  output wire [2:0] output_port_o,
  output wire [2:0] output_port_oe,
  output wire rom_bank_select
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [2:0] hcnt_ff;
  reg [1:0] phase_ff;
  reg [`DIV_WIDTH-1:0] div_ff;
  reg [3:0] out_port_ff;
  reg arm_ff;
  reg int_hold_ff;
  reg wake_en_ff;
  reg [7:0] wake_src_ff;
  reg ack_ff;
  reg [7:0] sync1_ff;
  reg [7:0] sync2_ff;
  reg [7:0] sync3_ff;
  reg [7:0] edge1_ff;
  reg [7:0] edge2_ff;
  reg [7:0] edge3_ff;
  wire [7:0] pins_raw;
  wire [7:0] edge_seen;
  wire [7:0] edge_hit;
  wire wake_hit;
  wire take_int;
  wire bus_req;
  wire bus_take;
  wire running;

  assign pins_raw = {second_input_port, first_input_port};
  assign running = (state_ff == `ST_RUN) || (state_ff == `ST_HALT_PEND) ||
                   (state_ff == `ST_WAKE);

  // Byte-lane test, used by every register write
  function lane0;
    input [3:0] be;
    begin
      lane0 = be[0];
    end
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Stage one feeds only stage two; the port value moves only when
  // stages two and three agree, which rejects a single-cycle glitch.
  // three-stage synchroniser
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_ff <= 8'hFF;
      sync2_ff <= 8'hFF;
      sync3_ff <= 8'hFF;
      port_in <= 8'hFF;
    end
    else
    begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      port_in <= (sync2_ff & sync3_ff) | (port_in & (sync2_ff | sync3_ff));
    end
  end

  assign pullup_en = PULLUP_MASK;

  // ****************************************************************
  // Wake edge capture
  // ****************************************************************
  wake_edge_latch #(
    .WAKE_MASK(WAKE_MASK)
  ) u_edge (
    .pin_raw(pins_raw),
    .arm_b(arm_ff),
    .edge_seen(edge_seen)
  );

  // Catcher outputs are asynchronous to sys_clk, so they cross the same way
  // synchronise captured edges
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      edge1_ff <= 8'h00;
      edge2_ff <= 8'h00;
      edge3_ff <= 8'h00;
    end
    else
    begin
      edge1_ff <= edge_seen;
      edge2_ff <= edge1_ff;
      edge3_ff <= edge2_ff;
    end
  end

  assign edge_hit = edge2_ff & edge3_ff;
  assign wake_hit = (|edge_hit) & wake_en_ff;
  // oscillator restarts straight from the catchers
  assign osc_restart = (|edge_seen) & wake_en_ff;

  // ****************************************************************
  // Halt state machine
  // ****************************************************************
  // A pending interrupt is taken once the core is out of a subroutine
  // held until return
  assign take_int = int_hold_ff & int_enable & !in_subroutine &&
                    (state_ff == `ST_RUN);

  // only a wake or reset ends halt
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      `ST_RUN:
        if (halt_instr)
          nxt_state = `ST_HALT_PEND;
      `ST_HALT_PEND:
        if (hcnt_ff == `HALT_STATES)
          nxt_state = `ST_HALT;
      `ST_HALT:
        if (wake_hit)
          nxt_state = `ST_WAKE;
      `ST_WAKE:
        nxt_state = `ST_RUN;
      default:
        nxt_state = `ST_RUN;
    endcase
  end

  // Halt instruction length counted in oscillator states
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff <= `ST_RUN;
      hcnt_ff <= 3'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (state_ff == `ST_HALT_PEND)
        hcnt_ff <= hcnt_ff + 3'h1;
      else
        hcnt_ff <= 3'h0;
    end
  end

  // Catchers armed only in halt; low arm clears them on the way out
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      arm_ff <= 1'b0;
    else
      arm_ff <= (nxt_state == `ST_HALT);
  end

  assign sys_clk_run = running;
  assign lcd_blank = (state_ff == `ST_HALT);

  // ****************************************************************
  // Program counter loading
  // ****************************************************************
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pc_load <= 1'b1;
      pc_load_value <= `RESET_PC;
      call_push <= 1'b0;
      int_hold_ff <= 1'b0;
    end
    else
    begin
      pc_load <= 1'b0;
      call_push <= 1'b0;
      if ((state_ff == `ST_HALT) && wake_hit)
      begin
        pc_load <= 1'b1;
        if (int_enable && !in_subroutine)
        begin
          pc_load_value <= `WAKE_PC;
          call_push <= 1'b1;
        end
        else
        begin
          pc_load_value <= next_pc;
          int_hold_ff <= int_enable;
        end
      end
      else if (take_int)
      begin
        pc_load <= 1'b1;
        pc_load_value <= `WAKE_PC;
        call_push <= 1'b1;
        int_hold_ff <= 1'b0;
      end
      else if (!int_enable)
        int_hold_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // Machine cycle and derived clocks
  // ****************************************************************
  // four states per cycle
  // frozen while halted, so nothing changes
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_ff <= 2'h0;
      div_ff <= {`DIV_WIDTH{1'b0}};
    end
    else if (running)
    begin
      phase_ff <= phase_ff + 2'h1;
      div_ff <= div_ff + {{(`DIV_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign first_cycle_state = running && (phase_ff == 2'h0);
  assign last_cycle_state = running && (phase_ff == 2'h3);
  assign lcd_clk = div_ff[LCD_TAP];
  assign sound_clk = div_ff[SOUND_TAP];
  assign timer_src = div_ff[TIMER_TAP];

  // ****************************************************************
  // Output port
  // ****************************************************************
  // reset loads all ones; open-drain bits are released, not driven
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      out_port_ff <= `OUT_PORT_RESET;
    else if (port_write_instr)
      out_port_ff <= port_wdata;
  end

  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1)
    begin : g_out
      if (OPEN_DRAIN_MASK[k])
      begin : g_od
        assign output_port_o[k] = 1'b0;
        assign output_port_oe[k] = !out_port_ff[k];
      end
      else
      begin : g_pp
        assign output_port_o[k] = out_port_ff[k];
        assign output_port_oe[k] = 1'b1;
      end
    end
  endgenerate

  assign rom_bank_select = out_port_ff[3];

  // ****************************************************************
  // Avalon-MM slave
  // ****************************************************************
  // One wait cycle per access; answer at the second edge
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & !ack_ff;
  assign bus_take = bus_req & ack_ff;

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_ff <= 1'b0;
      avs_readdata <= 32'h00000000;
      wake_en_ff <= `CTRL_RESET;
      wake_src_ff <= 8'h00;
    end
    else
    begin
      ack_ff <= bus_req & !ack_ff;
      if (avs_read && !ack_ff)
      begin
        case (avs_address)
          `REG_CTRL: avs_readdata <= {31'h00000000, wake_en_ff};
          `REG_STATUS: avs_readdata <= {24'h000000, out_port_ff, int_hold_ff,
                                        lcd_blank, state_ff};
          `REG_PORTS: avs_readdata <= {24'h000000, port_in};
          `REG_WAKE_SRC: avs_readdata <= {24'h000000, wake_src_ff};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
      if (bus_take && avs_write && lane0(avs_byteenable) &&
          (avs_address == `REG_CTRL))
        wake_en_ff <= avs_writedata[`CTRL_WAKE_EN_BIT];
      // Write-one-to-clear; a new wake source in the same cycle wins
      if (bus_take && avs_write && lane0(avs_byteenable) &&
          (avs_address == `REG_WAKE_SRC))
        wake_src_ff <= (wake_src_ff & ~avs_writedata[7:0]) |
                       (((state_ff == `ST_HALT) && wake_hit) ? edge_hit : 8'h00);
      else if ((state_ff == `ST_HALT) && wake_hit)
        wake_src_ff <= wake_src_ff | edge_hit;
    end
  end

endmodule

`default_nettype wire

// *** hdl/halt_wakeup_defines.vh ***
/*
  Constants for the halt, wake-up and port block: register offsets, reset
  values, state codes, vectors and timing counts.
  Assumes inclusion by bare name from the design files only.
*/
`ifndef HALT_WAKEUP_DEFINES_VH
`define HALT_WAKEUP_DEFINES_VH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_PORTS 4'h8
`define REG_WAKE_SRC 4'hC

`define CTRL_WAKE_EN_BIT 0
`define CTRL_RESET 1'b1

// ****************************************************************
// Reset values and vectors
// ****************************************************************
`define OUT_PORT_RESET 4'hF
`define RESET_PC 12'h000
`define WAKE_PC 12'h008

// ****************************************************************
// States and timing
// ****************************************************************
`define ST_RUN 2'h0
`define ST_HALT_PEND 2'h1
`define ST_HALT 2'h2
`define ST_WAKE 2'h3

`define STATES_PER_CYCLE 3'h4
`define HALT_INSTR_CYCLES 3'h2
`define HALT_STATES 3'h7
`define DIV_WIDTH 16

`endif

// *** hdl/wake_edge_latch.v ***
/*
  Clockless falling-edge catchers, one per input bit selected as wake source.
  Assumes arm_b is a glitch-free flip-flop output; while it is low every
  catcher is held clear.
*/
`timescale 1ns/10ps
`default_nettype none

module wake_edge_latch #(
  parameter [7:0] WAKE_MASK = 8'hFF
) (
  input wire [7:0] pin_raw,
  input wire arm_b,
  output wire [7:0] edge_seen
);

  // ****************************************************************
  // Edge catchers
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_bit
      if (WAKE_MASK[i])
      begin : g_on
        reg seen_ff;
        always @(negedge pin_raw[i] or negedge arm_b)
        begin
          if (!arm_b)
            seen_ff <= 1'b0;
          else
            seen_ff <= 1'b1;
        end
        assign edge_seen[i] = seen_ff;
      end
      else
      begin : g_off
        assign edge_seen[i] = 1'b0;
      end
    end
  endgenerate

endmodule

`default_nettype wire

// *** testbench/halt_wakeup_and_ports_bench.sv ***
/*
  Bench for the halt, wake and port block and its pin model.
  Assumes the design, monitor and model files are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s exp %0h got %0h", nm, e, g); end end
module halt_wakeup_and_ports_bench;
  logic sys_clk, rst_b, avs_read, avs_write, halt_instr, port_write_instr;
  logic int_enable, in_subroutine, pc_load, call_push, sys_clk_run, osc_restart;
  logic lcd_blank, first_cycle_state, last_cycle_state, lcd_clk, sound_clk;
  logic timer_src, rom_bank_select, avs_waitrequest;
  logic [3:0] avs_address, port_wdata;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [11:0] next_pc, pc_load_value;
  logic [7:0] pins, drv, drv_en, pullup_en, port_in;
  logic [2:0] output_port_o, output_port_oe, pa_level;
  int err_total = 0;
  int checks_done = 0;
  // Bit 4 is no wake source, bit 7 has no pull-up
  halt_wakeup_and_ports #(.WAKE_MASK(8'hEF), .PULLUP_MASK(8'h7F), .OPEN_DRAIN_MASK(3'h2))
  halt_wakeup_and_ports_inst (.*, .avs_byteenable(4'hF), .first_input_port(pins[3:0]),
    .second_input_port(pins[7:4]));
  port_pins_model port_pins_model_inst (.drv(drv), .drv_en(drv_en), .pullup_en(pullup_en),
    .pa_o(output_port_o), .pa_oe(output_port_oe), .pins(pins), .pa_level(pa_level));
  // ******
  // Clock and tasks
  // ******
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task test_done;
    begin
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // A spent wait ends the run
  task guard(input int n);
    begin
      if (n >= 40)
      begin
        err_total++;
        $display("Error wait exp 40 got %0d", n);
        test_done();
      end
    end
  endtask
  // Held until waitrequest is seen low
  // Answer is read in the low phase, so it is what the next rising edge sees
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    logic ws;
    begin
      n = 0;
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      do
      begin
        @(negedge sys_clk);
        ws = avs_waitrequest;
        rd = avs_readdata;
        @(posedge sys_clk);
        n++;
      end while (ws !== 1'b0 && n < 40);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      guard(n);
      @(posedge sys_clk);
    end
  endtask
  task wait_load;
    int n;
    begin
      n = 0;
      while (pc_load !== 1'b1 && n < 40)
      begin
        @(negedge sys_clk);
        n++;
      end
      guard(n);
    end
  endtask
  task port_wr(input logic [3:0] v);
    begin
      port_write_instr <= 1'b1;
      port_wdata <= v;
      @(posedge sys_clk);
      port_write_instr <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  // ******
  // Scenarios
  // ******
  task t_reset;
    begin
      @(negedge sys_clk);
      `CHK("pc", 13'h1000, {rom_bank_select, pc_load_value})
      `CHK("pa", 6'h2F, {output_port_oe, pa_level})
      `CHK("pullup", 8'h7F, pullup_en)
      `CHK("run", 3'h6, {pc_load, sys_clk_run, lcd_blank})
      @(posedge sys_clk);
      $display("reset test done");
    end
  endtask
  task t_regs;
    begin
      bus(1'b0, 4'h0, 32'h0);
      `CHK("ctrl", 32'h1, rd)
      bus(1'b0, 4'h4, 32'h0);
      `CHK("status", 32'hF0, rd)
      bus(1'b1, 4'h6, 32'h5);
      bus(1'b0, 4'h6, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      drv <= 8'h5D;
      repeat (8) @(posedge sys_clk);
      bus(1'b0, 4'h8, 32'h0);
      `CHK("ports", 32'h5D, rd)
      `CHK("port_in", 8'h5D, port_in)
      // Released bit 0 must be lifted by its pull-up
      drv <= 8'hFE;
      drv_en <= 8'hFE;
      repeat (8) @(posedge sys_clk);
      `CHK("pullup_pin", 8'hFF, port_in)
      drv_en <= 8'hFF;
      drv <= 8'hFF;
      $display("register test done");
    end
  endtask
  task t_port;
    begin
      port_wr(4'h5);
      `CHK("pa5", 4'h5, {rom_bank_select, pa_level})
      port_wr(4'hA);
      `CHK("paA", 4'hA, {rom_bank_select, pa_level})
      $display("port test done");
    end
  endtask
  // Rising and unselected edges first, then a real wake
  task t_halt(input logic ie, input logic sub, input logic [11:0] pc);
    int n;
    begin
      n = 0;
      int_enable <= ie;
      in_subroutine <= sub;
      drv <= 8'hFE;
      halt_instr <= 1'b1;
      @(posedge sys_clk);
      halt_instr <= 1'b0;
      while (sys_clk_run !== 1'b0 && n < 40)
      begin
        @(negedge sys_clk);
        n++;
      end
      guard(n);
      // Eight states after the taking edge, seen at the following low phase
      `CHK("halt_len", 9, n)
      @(posedge sys_clk);
      drv <= 8'hEF;
      repeat (12) @(posedge sys_clk);
      `CHK("halted", 2'h1, {sys_clk_run, lcd_blank})
      drv <= 8'hEE;
      wait_load;
      `CHK("pc", pc, pc_load_value)
      `CHK("call", ie & !sub, call_push)
      `CHK("bank", 1'b1, rom_bank_select)
      n = 0;
      while (sys_clk_run !== 1'b1 && n < 40)
      begin
        @(negedge sys_clk);
        n++;
      end
      guard(n);
      `CHK("unblank", 1'b0, lcd_blank)
      @(posedge sys_clk);
      drv <= 8'hFF;
      bus(1'b0, 4'hC, 32'h0);
      `CHK("wake_src", 32'h1, rd)
      bus(1'b1, 4'hC, 32'hFF);
      $display("halt test done");
    end
  endtask
  task t_held;
    begin
      t_halt(1'b1, 1'b1, 12'h123);
      in_subroutine <= 1'b0;
      wait_load;
      `CHK("held_pc", 13'h1008, {rom_bank_select, pc_load_value})
      `CHK("held_call", 1'b1, call_push)
      $display("held wake test done");
    end
  endtask
  initial
  begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    halt_instr = 1'b0;
    port_write_instr = 1'b0;
    port_wdata = 4'h0;
    int_enable = 1'b0;
    in_subroutine = 1'b0;
    next_pc = 12'h123;
    drv = 8'hFF;
    drv_en = 8'hFF;
    repeat (16) @(posedge sys_clk);
    t_reset;
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_regs;
    t_port;
    t_halt(1'b1, 1'b0, 12'h008);
    t_halt(1'b0, 1'b0, 12'h123);
    t_held;
    test_done;
  end
endmodule
bind halt_wakeup_and_ports halt_wakeup_and_ports_monitor #(.OPEN_DRAIN_MASK(OPEN_DRAIN_MASK)) mon_inst (.*);
`default_nettype wire

// *** testbench/halt_wakeup_and_ports_monitor.sv ***
/*
  Checker on the ports of the halt, wake and port block.
  Assumes it is bound onto the top module.
*/
`timescale 1ns/10ps
`default_nettype none
module halt_wakeup_and_ports_monitor #(
  parameter [2:0] OPEN_DRAIN_MASK = 3'h0
) (
  input wire sys_clk,
  input wire rst_b,
  input wire halt_instr,
  input wire port_write_instr,
  input wire [3:0] port_wdata,
  input wire pc_load,
  input wire [11:0] pc_load_value,
  input wire call_push,
  input wire sys_clk_run,
  input wire osc_restart,
  input wire lcd_blank,
  input wire first_cycle_state,
  input wire lcd_clk,
  input wire sound_clk,
  input wire timer_src,
  input wire [2:0] output_port_o,
  input wire [2:0] output_port_oe,
  input wire rom_bank_select
);
  // ******
  // Properties
  // ******
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_blank; !sys_clk_run |-> lcd_blank; endproperty
  a_blank: assert property (p_blank) else $error("display not blank");
  property p_enter; halt_instr && sys_clk_run && !lcd_blank |-> sys_clk_run[*7] ##[1:3] !sys_clk_run; endproperty
  a_enter: assert property (p_enter) else $error("halt entry timing");
  property p_vec; call_push |-> pc_load && pc_load_value == 12'h008; endproperty
  a_vec: assert property (p_vec) else $error("call without vector");
  property p_resume; $rose(sys_clk_run) |-> pc_load || $past(pc_load); endproperty
  a_resume: assert property (p_resume) else $error("resume without load");
  property p_wake; osc_restart && !sys_clk_run |-> ##[1:5] pc_load; endproperty
  a_wake: assert property (p_wake) else $error("wake too slow");
  property p_drive; port_write_instr |=> rom_bank_select == $past(port_wdata[3])
    && output_port_oe == (~OPEN_DRAIN_MASK | ~$past(port_wdata[2:0]))
    && (output_port_o & output_port_oe) == ($past(port_wdata[2:0]) & ~OPEN_DRAIN_MASK); endproperty
  a_drive: assert property (p_drive) else $error("port drive wrong");
  property p_cycle; first_cycle_state && sys_clk_run ##1 sys_clk_run[*4] |-> first_cycle_state; endproperty
  a_cycle: assert property (p_cycle) else $error("cycle not four states");
  property p_frozen; !sys_clk_run ##1 !sys_clk_run |-> $stable({lcd_clk, sound_clk, timer_src}); endproperty
  a_frozen: assert property (p_frozen) else $error("clock ran in halt");
endmodule
`default_nettype wire

// *** testbench/port_pins_model.sv ***
/*
  Far side: input pins with optional pull-ups, loads on the output port.
  Assumes the bench changes pin drive just after a clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module port_pins_model (
  input wire logic [7:0] drv,
  input wire logic [7:0] drv_en,
  input wire logic [7:0] pullup_en,
  input wire logic [2:0] pa_o,
  input wire logic [2:0] pa_oe,
  output logic [7:0] pins,
  output logic [2:0] pa_level
);
  logic [7:0] last_v = 8'h00;
  // ******
  // Pin levels
  // ******
  // pull-up or drift
  always @*
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (drv_en[i])
        last_v[i] = drv[i];
      pins[i] = drv_en[i] ? drv[i] : (pullup_en[i] ? 1'b1 : ~last_v[i]);
    end
  end
  assign pa_level = (pa_o & pa_oe) | ~pa_oe;
endmodule
`default_nettype wire
